/* File: core/scp_reader.sv */
// read side of a serial configuration memory: counter, serial data and chain select
`timescale 1ns/1ns

module scp_reader
#(
    parameter int                DEPTH          = scp_pkg::SCP_DEPTH_DEFAULT,
    parameter logic              GATE_POLARITY  = scp_pkg::SCP_GATE_ACTIVE_HIGH,
    parameter logic [DEPTH-1:0]  CONTENTS       = '0
)
(
    // clock and power-up reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // control pins from the host and the previous device
    input  wire scp_pkg::scp_pins_t pins_in,
    // serial data pin and chain select out
    output scp_pkg::scp_out_t       pins_out,
    // low-power standby indication
    output logic                    standby_mode
);
    import scp_pkg::*;

    // counter width follows the capacity
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST_ADDRESS_VALUE = AW'(DEPTH - 1); // highest address
    localparam logic [AW-1:0] ADDR_ZERO          = '0;            // first stored bit

    // decoded control levels
    logic            gate_reset;                     // reset level present on the gate pin
    logic            chain_enabled;                  // chain select in is low
    logic            clock_rise;                     // rising edge of the host clock
    logic            count_step;                     // this edge moves the counter
    logic            at_last;                        // counter sits on the last address

    // sequencer and counter
    scp_state_t      state_reg;                      // read sequencer state
    scp_state_t      state_next;                     // its next value
    logic [AW-1:0]   addr_reg;                       // bit address counter
    logic [AW-1:0]   addr_next;                      // its next value

    // outputs
    logic            stored_bit;                     // bit at the current address
    logic            data_reg;                       // registered serial data
    logic            data_oe;                        // serial pin driven
    logic            chain_select_out_b;             // chain select out, active low

    // polarity decode of the gate pin; a function since both the logic and
    // the checks below need the same reading
    function automatic logic gate_is_reset(input logic level, input logic polarity);
        gate_is_reset = (polarity == SCP_GATE_ACTIVE_HIGH) ? level : ~level;
    endfunction : gate_is_reset

    // the option is a build choice, standing in for the programmed fuse
    assign gate_reset    = gate_is_reset(pins_in.reset_gate, GATE_POLARITY);
    assign chain_enabled = ~pins_in.chain_select_in_b;

    // edge of the host clock; the host drives it, the device only samples it
    scp_edge_detect u_edge
    (
        .clk        (clk),
        .rst_b      (rst_b),
        .level_in   (pins_in.host_config_clock),
        .rise_pulse (clock_rise)
    );

    // the stored program
    scp_bit_store
    #(
        .DEPTH    (DEPTH),
        .AW       (AW),
        .CONTENTS (CONTENTS)
    )
    u_store
    (
        .rd_index (addr_reg),
        .rd_bit   (stored_bit)
    );

    // a rise only counts while enabled, out of reset and not yet spent
    assign count_step = clock_rise & chain_enabled & ~gate_reset
                      & (state_reg != SCP_ST_SPENT);
    assign at_last    = (addr_reg == LAST_ADDRESS_VALUE);

    // next state of the sequencer
    always_comb
    begin
        state_next = state_reg;
        if (gate_reset)
        begin
            // a reset level wins over any edge
            state_next = SCP_ST_HELD;
        end
        else
        begin
            case (state_reg)
                SCP_ST_HELD:
                begin
                    // released: read from the first bit, and a rise in this
                    // same cycle already counts
                    state_next = (count_step && at_last) ? SCP_ST_SPENT : SCP_ST_READ;
                end
                SCP_ST_READ:
                begin
                    // the rise after the last bit ends this device's share
                    if (count_step && at_last)
                    begin
                        state_next = SCP_ST_SPENT;
                    end
                end
                SCP_ST_SPENT:
                begin
                    // only the gate or the power-up reset leaves here
                    state_next = SCP_ST_SPENT;
                end
                default:
                begin
                    state_next = SCP_ST_HELD;
                end
            endcase
        end
    end

    // next address; it does not wrap to zero past the end, it freezes
    always_comb
    begin
        addr_next = addr_reg;
        if (gate_reset)
        begin
            addr_next = ADDR_ZERO;
        end
        else if (count_step && !at_last)
        begin
            addr_next = AW'(addr_reg + 1'b1);
        end
    end

    // sequencer state; power-up starts at the first stored program
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= SCP_ST_READ;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // address counter; only the gate or the power-up reset clears it, so a restart without a
    // gate reset carries on where the last configuration stopped
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addr_reg <= ADDR_ZERO;
        end
        else
        begin
            addr_reg <= addr_next;
        end
    end

    // serial data comes from a flip-flop, one clk after the address settles
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            data_reg <= SCP_DATA_RESET;
        end
        else
        begin
            data_reg <= stored_bit;
        end
    end

    // pin drive: floats in a gate reset, in standby and once spent
    assign data_oe = chain_enabled & ~gate_reset
                   & (state_reg != SCP_ST_SPENT);

    // chain out follows chain in once read, high whenever the gate resets
    assign chain_select_out_b = ~(chain_enabled & ~gate_reset
                                & (state_reg == SCP_ST_SPENT));

    // outputs
    assign pins_out.data               = data_reg;
    assign pins_out.data_oe            = data_oe;
    assign pins_out.chain_select_out_b = chain_select_out_b;
    assign standby_mode                = ~chain_enabled;

    // sequences used by the checks below
    sequence s_last_rise;
        (state_reg != SCP_ST_SPENT) && at_last && clock_rise && chain_enabled && !gate_reset;
    endsequence

    sequence s_middle_rise;
        (state_reg != SCP_ST_SPENT) && !at_last && clock_rise && chain_enabled && !gate_reset;
    endsequence

    // reset level clears the counter by the next edge
    a_reset_clears_addr: assert property (
        @(posedge clk) disable iff (!rst_b)
        gate_reset |=> (addr_reg == ADDR_ZERO) && (state_reg == SCP_ST_HELD))
        else $error("gate reset did not clear the counter");

    // reset level floats the pin and keeps chain out high
    a_reset_floats_out: assert property (
        @(posedge clk) disable iff (!rst_b)
        gate_reset |-> !pins_out.data_oe && pins_out.chain_select_out_b)
        else $error("pin driven during gate reset");

    // standby floats the pin whatever the gate does
    a_standby_floats: assert property (
        @(posedge clk) disable iff (!rst_b)
        !chain_enabled |-> standby_mode && !pins_out.data_oe && pins_out.chain_select_out_b)
        else $error("pin driven in standby");

    // a qualifying rise below the last address moves the address by exactly one
    a_addr_steps_one: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_middle_rise |=> addr_reg == AW'($past(addr_reg) + 1'b1))
        else $error("address did not step by one");

    // without a rise and without reset the counter stands
    a_addr_holds_idle: assert property (
        @(posedge clk) disable iff (!rst_b)
        (!clock_rise || !chain_enabled) && !gate_reset |=> $stable(addr_reg))
        else $error("address moved without a qualifying rise");

    // the rise after the last bit spends the device and floats the pin
    a_last_rise_spends: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_last_rise ##1 (chain_enabled && !gate_reset) |-> (state_reg == SCP_ST_SPENT)
            && !pins_out.data_oe && !pins_out.chain_select_out_b)
        else $error("device not spent after the last bit");

    // once spent the counter and state stay put until a reset
    a_spent_frozen: assert property (
        @(posedge clk) disable iff (!rst_b)
        (state_reg == SCP_ST_SPENT) && !gate_reset |=> (state_reg == SCP_ST_SPENT)
            && (addr_reg == LAST_ADDRESS_VALUE) && $stable(addr_reg))
        else $error("spent device changed its counter");

    // spent chain out mirrors chain in while the gate is inactive
    a_chain_follows: assert property (
        @(posedge clk) disable iff (!rst_b)
        (state_reg == SCP_ST_SPENT) && !gate_reset
            |-> pins_out.chain_select_out_b == pins_in.chain_select_in_b)
        else $error("chain out does not follow chain in");

    // driven data is the bit stored at the address of the previous cycle
    a_data_matches: assert property (
        @(posedge clk) disable iff (!rst_b)
        chain_enabled && !gate_reset ##1 pins_out.data_oe
            |-> pins_out.data == CONTENTS[$past(addr_reg)])
        else $error("driven bit differs from the stored bit");

    // power-up reset leaves the first address and the reading state
    a_power_up_clear: assert property (
        @(posedge clk)
        !rst_b |=> (addr_reg == ADDR_ZERO) && (state_reg == SCP_ST_READ))
        else $error("power-up reset did not clear the counter");

    // chain out rests high until this device has been read through
    a_chain_out_idle: assert property (
        @(posedge clk) disable iff (!rst_b)
        (state_reg != SCP_ST_SPENT) |-> pins_out.chain_select_out_b)
        else $error("chain out low before the last bit");

    // a low chain select in drives the pin while reading
    a_enable_drives: assert property (
        @(posedge clk) disable iff (!rst_b)
        chain_enabled && !gate_reset && (state_reg != SCP_ST_SPENT) |-> pins_out.data_oe)
        else $error("pin floats while enabled and reading");

    // leaving the gate reset always resumes reading
    a_release_reads: assert property (
        @(posedge clk) disable iff (!rst_b)
        (state_reg == SCP_ST_HELD) && !gate_reset |=> (state_reg != SCP_ST_HELD))
        else $error("sequencer stuck after gate release");

endmodule : scp_reader

/* File: core/scp_pkg.sv */
// shared types and constants for the serial configuration memory reader
package scp_pkg;

    // storage sizes, in bits
    localparam int SCP_DEPTH_DEFAULT      = 65536;   // default capacity of one device
    localparam int SCP_LENGTH_COUNT_LIMIT = 16777216; // longest clock run a master may issue

    // reset values of the read side
    localparam logic SCP_DATA_RESET       = 1'b0;    // data bit shown before any read
    localparam logic SCP_CHAIN_OUT_RESET  = 1'b1;    // chain select out idles high (inactive)
    localparam logic SCP_EDGE_PREV_RESET  = 1'b0;    // clock history after power-up

    // polarity option of the reset/output-gate pin
    localparam logic SCP_GATE_ACTIVE_HIGH = 1'b1;    // default: a high level resets
    localparam logic SCP_GATE_ACTIVE_LOW  = 1'b0;    // inverted option: a low level resets

    // read sequencer states
    typedef enum logic [1:0] {
        SCP_ST_HELD  = 2'b00,                        // reset level on the gate pin
        SCP_ST_READ  = 2'b01,                        // counting through the store
        SCP_ST_SPENT = 2'b10                         // counted past the last address
    } scp_state_t;

    // control pins as they arrive from the host side
    typedef struct packed {
        logic host_config_clock;                     // configuration clock from the host
        logic reset_gate;                            // reset/output-gate input, polarity per option
        logic chain_select_in_b;                     // chain select in, active low
    } scp_pins_t;

    // serial data pin as data and enable, plus chain select out
    typedef struct packed {
        logic data;                                  // stored bit
        logic data_oe;                               // high while the pin is driven
        logic chain_select_out_b;                    // chain select out, active low
    } scp_out_t;

endpackage : scp_pkg

/* File: core/scp_edge_detect.sv */
// rising edge detector for the host configuration clock
`timescale 1ns/1ns
module scp_edge_detect
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // sampled level and its rising edge
    input  wire logic level_in,
    output logic      rise_pulse
);
    import scp_pkg::*;

    logic prev_reg;                                  // level seen on the last clk edge

    // history of the level; the pin is taken as synchronous, so no extra stages
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prev_reg <= SCP_EDGE_PREV_RESET;
        end
        else
        begin
            prev_reg <= level_in;
        end
    end

    // one-cycle pulse on a low-to-high change
    assign rise_pulse = level_in & ~prev_reg;

endmodule : scp_edge_detect

/* File: core/scp_bit_store.sv */
// one-time-programmed bit store, read one bit at a time by index
`timescale 1ns/1ns
module scp_bit_store
#(
    parameter int                DEPTH    = scp_pkg::SCP_DEPTH_DEFAULT,
    parameter int                AW       = $clog2(DEPTH),
    parameter logic [DEPTH-1:0]  CONTENTS = '0
)
(
    // read port
    input  wire logic [AW-1:0] rd_index,
    output logic               rd_bit
);
    import scp_pkg::*;

    // contents are fixed at build time, as the fuses would be after programming;
    // an index past the end reads as zero rather than wrapping
    always_comb
    begin
        rd_bit = 1'b0;
        if (int'(rd_index) < DEPTH)
        begin
            rd_bit = CONTENTS[rd_index];
        end
    end

endmodule : scp_bit_store

/* File: bench/scp_host_model.sv */
// master-side partner: makes the configuration clock and captures the serial bits
`timescale 1ns/1ns
module scp_host_model
(
    // system clock
    clk,
    // serial line from the memory
    data,
    data_oe,
    // configuration clock to every memory
    host_config_clock
);
    import scp_pkg::*;
    input  wire logic clk;
    input  wire logic data;
    input  wire logic data_oe;
    output logic      host_config_clock;

    logic [15:0] got_bits;    // captured bits, first one at index 0
    int          got_count;   // bits captured since the bench cleared it
    logic        host_mode_select_bit0; // mode pins of the host; all low picks master serial
    logic        host_mode_select_bit1;
    logic        host_mode_select_bit2;
    logic        master_serial;         // host clocks the memory only in this mode

    assign master_serial = ~(host_mode_select_bit0 | host_mode_select_bit1 | host_mode_select_bit2);

    initial
    begin
        host_config_clock = 1'b0;
        got_bits          = 16'h0000;
        got_count         = 0;
        host_mode_select_bit0 = 1'b0;
        host_mode_select_bit1 = 1'b0;
        host_mode_select_bit2 = 1'b0;
    end

    // one pulse per bit: sample the line, then rise; low for three cycles so
    // the next bit has settled before it is sampled
    task automatic pulse_bits(input int n);
        for (int i = 0; i < n && i < SCP_LENGTH_COUNT_LIMIT && master_serial; i++)
        begin
            @(negedge clk);
            // a floating line is ignored, never read as a bit
            if (data_oe === 1'b1 && got_count < 16)
            begin
                got_bits[got_count] = data;
                got_count++;
            end
            host_config_clock = 1'b1;
            repeat (2) @(negedge clk);
            host_config_clock = 1'b0;
            repeat (2) @(negedge clk);
        end
    endtask : pulse_bits
endmodule : scp_host_model

/* File: bench/scp_reader_bench.sv */
// self-checking bench for the serial configuration memory reader
`timescale 1ns/1ns
`define CHK(what, exp, got) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module scp_reader_bench;
    import scp_pkg::*;
    localparam int         DEPTH = 8;      // short store keeps the run brief
    localparam logic [7:0] STORE = 8'hB5;  // programmed pattern
    // truth-table rows {gate, chain in, oe, chain out, standby}
    localparam logic [4:0] ROWS [4] = '{5'h06, 5'h12, 5'h0B, 5'h1B};

    logic      clk;
    logic      rst_b;
    logic      gate_on;     // gate at its reset level
    logic      cs_in_b;     // chain select in
    logic      cfg_clk;     // host clock from the partner
    scp_pins_t pins_hi;     // pins for the active-high option
    scp_pins_t pins_lo;     // pins for the active-low option
    scp_out_t  out_hi;
    scp_out_t  out_lo;
    logic      standby_hi;
    logic      standby_lo;
    int        num_errors = 0;
    int        compares   = 0;

    // the low option sees the inverted line, so both must act alike
    assign pins_hi = {cfg_clk, gate_on, cs_in_b};
    assign pins_lo = {cfg_clk, ~gate_on, cs_in_b};

    scp_reader #(.DEPTH(DEPTH), .GATE_POLARITY(SCP_GATE_ACTIVE_HIGH), .CONTENTS(STORE)) scp_reader_i
    (.clk(clk), .rst_b(rst_b), .pins_in(pins_hi), .pins_out(out_hi), .standby_mode(standby_hi));
    scp_reader #(.DEPTH(DEPTH), .GATE_POLARITY(SCP_GATE_ACTIVE_LOW), .CONTENTS(STORE)) scp_reader_low_i
    (.clk(clk), .rst_b(rst_b), .pins_in(pins_lo), .pins_out(out_lo), .standby_mode(standby_lo));
    scp_host_model scp_host_model_i
    (.clk(clk), .data(out_hi.data), .data_oe(out_hi.data_oe), .host_config_clock(cfg_clk));

    // clock, 4 ns period
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // verdict and end of run
    task automatic conclude();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    // change the pins at a falling edge and let them settle
    task automatic set_pins(input logic gate, input logic cs_b);
        @(negedge clk);
        gate_on = gate;
        cs_in_b = cs_b;
        repeat (2) @(negedge clk);
    endtask : set_pins

    // compare status pins, and both polarity options against each other
    task automatic check_pins(input string what, input logic oe, input logic chain_out_b, input logic sb);
        `CHK(what, {oe, chain_out_b, sb}, {out_hi.data_oe, out_hi.chain_select_out_b, standby_hi})
        `CHK(what, {out_hi, standby_hi}, {out_lo, standby_lo})
    endtask : check_pins

    // clock n bits and expect the store from address first on
    task automatic read_bits(input int first, input int n, input int seen);
        scp_host_model_i.got_count = 0;
        scp_host_model_i.pulse_bits(n);
        `CHK("bit count", seen, scp_host_model_i.got_count)
        for (int i = 0; i < seen; i++)
            `CHK("serial bit", STORE[first + i], scp_host_model_i.got_bits[i])
    endtask : read_bits

    // watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        repeat (5000) @(posedge clk);
        num_errors++;
        conclude();
    end

    initial
    begin
        rst_b   = 1'b0;
        gate_on = 1'b0;
        cs_in_b = 1'b0;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        read_bits(0, 3, 3);
        // truth table of the control pins, one row at a time
        foreach (ROWS[r])
        begin
            set_pins(ROWS[r][4], ROWS[r][3]);
            check_pins("truth row", ROWS[r][2], ROWS[r][1], ROWS[r][0]);
        end
        set_pins(1'b0, 1'b0);
        // full read from a gate reset, then past the last address
        read_bits(0, DEPTH, DEPTH);
        check_pins("spent", 1'b0, 1'b0, 1'b0);
        read_bits(0, 2, 0);
        check_pins("still spent", 1'b0, 1'b0, 1'b0);
        // chain out follows chain in once read
        set_pins(1'b0, 1'b1);
        check_pins("follow high", 1'b0, 1'b1, 1'b1);
        set_pins(1'b0, 1'b0);
        check_pins("follow low", 1'b0, 1'b0, 1'b0);
        set_pins(1'b1, 1'b0);
        check_pins("gate on", 1'b0, 1'b1, 1'b0);
        set_pins(1'b0, 1'b0);
        check_pins("gate off", 1'b1, 1'b1, 1'b0);
        read_bits(0, 3, 3);
        // standby must freeze the counter; chain select rising mid-read inhibits the data at once
        set_pins(1'b0, 1'b1);
        check_pins("done high", 1'b0, 1'b1, 1'b1);
        read_bits(0, 2, 0);
        set_pins(1'b0, 1'b0);
        read_bits(3, 1, 1);
        // restart without a gate reset continues where it stopped
        read_bits(4, 4, 4);
        check_pins("spent again", 1'b0, 1'b0, 1'b0);
        // power-up reset in mid-read
        set_pins(1'b1, 1'b0);
        set_pins(1'b0, 1'b0);
        read_bits(0, 2, 2);
        @(negedge clk);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        read_bits(0, 2, 2);
        conclude();
    end
endmodule : scp_reader_bench
